// ==== dac_pkg.sv ====
package dac_pkg;

  // converter shape
  localparam int NUM_CHANNELS = 2;
  localparam int CODE_WIDTH = 16;
  localparam int LEVEL_WIDTH = CODE_WIDTH + 1;
  localparam int GAIN_WIDTH = 10;
  localparam int RANGE_WIDTH = 3;

  // channel codes
  localparam logic [CODE_WIDTH-1:0] CODE_ZERO_SCALE = 16'h0000;
  localparam logic [CODE_WIDTH-1:0] CODE_MIDSCALE = 16'h8000;
  localparam logic [CODE_WIDTH-1:0] CODE_MSB_FLIP = 16'h8000;
  localparam logic [LEVEL_WIDTH-1:0] LEVEL_MID_OFFSET = 17'h08000;

  // output range codes
  localparam logic [RANGE_WIDTH-1:0] RANGE_UNI_5 = 3'h0;
  localparam logic [RANGE_WIDTH-1:0] RANGE_UNI_10 = 3'h1;
  localparam logic [RANGE_WIDTH-1:0] RANGE_UNI_10P8 = 3'h2;
  localparam logic [RANGE_WIDTH-1:0] RANGE_BI_5 = 3'h3;
  localparam logic [RANGE_WIDTH-1:0] RANGE_BI_10 = 3'h4;
  localparam logic [RANGE_WIDTH-1:0] RANGE_BI_10P8 = 3'h5;

  // internal gain, hundredths
  localparam logic [GAIN_WIDTH-1:0] GAIN_UNI_5 = 10'h0C8;
  localparam logic [GAIN_WIDTH-1:0] GAIN_UNI_10 = 10'h190;
  localparam logic [GAIN_WIDTH-1:0] GAIN_UNI_10P8 = 10'h1B0;
  localparam logic [GAIN_WIDTH-1:0] GAIN_BI_5 = 10'h190;
  localparam logic [GAIN_WIDTH-1:0] GAIN_BI_10 = 10'h320;
  localparam logic [GAIN_WIDTH-1:0] GAIN_BI_10P8 = 10'h360;

  // command word fields
  localparam int CMD_WIDTH = 24;
  localparam logic [2:0] REG_DAC = 3'h0;
  localparam logic [2:0] REG_RANGE = 3'h1;
  localparam logic [2:0] REG_POWER = 3'h2;
  localparam logic [2:0] REG_CONTROL = 3'h3;
  localparam logic [2:0] ADDR_CH_A = 3'h0;
  localparam logic [2:0] ADDR_CH_B = 3'h2;
  localparam logic [2:0] ADDR_CH_ALL = 3'h4;
  localparam logic [2:0] CTRL_CONFIG = 3'h1;
  localparam logic [2:0] CTRL_CLEAR = 3'h4;
  localparam int CLEAR_SELECT_BIT = 2;
  localparam int POWER_CH_STRIDE = 2;
  localparam int POWER_REF_BIT = 4;

  // bus register map, byte addresses
  localparam int AXI_ADDR_WIDTH = 8;
  localparam logic [AXI_ADDR_WIDTH-1:0] OFFSET_COMMAND = 8'h00;
  localparam logic [AXI_ADDR_WIDTH-1:0] OFFSET_READBACK = 8'h04;
  localparam logic [AXI_ADDR_WIDTH-1:0] OFFSET_STATUS = 8'h08;
  localparam logic [AXI_ADDR_WIDTH-1:0] OFFSET_LEVEL_A = 8'h0C;
  localparam logic [AXI_ADDR_WIDTH-1:0] OFFSET_LEVEL_B = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // status and level word layout
  localparam int STATUS_CLEAR_PIN_BIT = 0;
  localparam int STATUS_CLEAR_SELECT_BIT = 1;
  localparam int STATUS_REF_BIT = 2;
  localparam int STATUS_POWER_LSB = 4;
  localparam int STATUS_RANGE_LSB = 8;
  localparam int STATUS_RANGE_STRIDE = 4;
  localparam int LEVEL_GAIN_LSB = 20;

  typedef struct packed {
    logic rw;
    logic spare;
    logic [2:0] reg_select;
    logic [2:0] channel_address;
    logic [CODE_WIDTH-1:0] data;
  } command_type;

  typedef struct packed {
    logic [CODE_WIDTH-1:0] code;
    logic signed [LEVEL_WIDTH-1:0] level;
    logic [GAIN_WIDTH-1:0] gain_x100;
  } channel_out_type;

endpackage : dac_pkg

// ==== channel_code_mapper.sv ====
`timescale 1ns/1ns
module channel_code_mapper
  import dac_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [CODE_WIDTH-1:0] code,
  input wire logic [RANGE_WIDTH-1:0] range,
  input wire logic twos_complement,
  output channel_out_type mapped
);

  logic bipolar;
  logic [CODE_WIDTH-1:0] offset_code;
  logic [LEVEL_WIDTH-1:0] next_level;
  logic [GAIN_WIDTH-1:0] next_gain;

  // R11 unipolar straight binary
  // R12 bipolar coding by pin
  assign bipolar = (range == RANGE_BI_5) || (range == RANGE_BI_10) || (range == RANGE_BI_10P8);
  assign offset_code = (bipolar && twos_complement) ? (code ^ CODE_MSB_FLIP) : code;

  // R14 R15 R16 R17 level in steps
  // bipolar subtracts half scale so midcode lands on zero volts
  assign next_level = bipolar ? ({1'b0, offset_code} - LEVEL_MID_OFFSET) : {1'b0, offset_code};

  // R13 gain per range
  always_comb begin
    unique case (range)
      RANGE_UNI_5: next_gain = GAIN_UNI_5;
      RANGE_UNI_10: next_gain = GAIN_UNI_10;
      RANGE_UNI_10P8: next_gain = GAIN_UNI_10P8;
      RANGE_BI_5: next_gain = GAIN_BI_5;
      RANGE_BI_10: next_gain = GAIN_BI_10;
      RANGE_BI_10P8: next_gain = GAIN_BI_10P8;
      default: next_gain = GAIN_UNI_5; // codes 6 and 7 fall back to the reset range
    endcase
  end

  // registered so the outputs never glitch on a range change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // R06 reset shows the 5 V unipolar gain, matching the reset range
      mapped <= '{code: CODE_ZERO_SCALE, level: '0, gain_x100: GAIN_UNI_5};
    end else begin
      mapped.code <= code;
      mapped.level <= next_level;
      mapped.gain_x100 <= next_gain;
    end
  end

endmodule : channel_code_mapper

// ==== dac_clear_and_code_mapping.sv ====
`timescale 1ns/1ns
// Operation
// R01: clear pin low forces every channel to zero-scale or midscale clear code.
// R02: after clear pin release, channels hold the cleared code until reprogrammed.
// R03: no channel takes a new value while the clear pin stays low.
// R04: the clear command performs the same clear without the pin.
// R05: reset zeroes every register; channels and reference start powered down.
// R06: reset range value selects the 5 V unipolar range.
// R07: host should first program the output range of all channels.
// R08: host should then power up needed channels and the reference.
// R09: data writes to a powered-down channel are discarded.
// R10: with an external reference the host keeps the reference powered down.
// R11: unipolar ranges read the code as straight binary.
// R12: bipolar ranges use offset binary or twos complement per coding pin.
// R13: gain is 2, 4, 4.32, 4, 8 or 8.64 by range.
// R14: unipolar output is reference times gain times code over full scale.
// R15: bipolar output subtracts half of gain times reference.
// R16: offset binary maps 0x8000 to zero volts.
// R17: twos complement maps zero code to zero volts.
// R18: command word is rw, three select, three address, sixteen data bits.
// R19: any clear loads the clear code into both data registers.
module dac_clear_and_code_mapping
  import dac_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_ADDR_WIDTH-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AXI_ADDR_WIDTH-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic output_clear_n,
  input wire logic bipolar_coding_select_pin,
  output channel_out_type channel_out [NUM_CHANNELS],
  output logic [NUM_CHANNELS-1:0] channel_powered,
  output logic reference_powered
);

  // write channel holding state
  logic aw_held;
  logic w_held;
  logic [AXI_ADDR_WIDTH-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic write_fire;
  logic write_hits_command;

  // command path
  logic [CMD_WIDTH-1:0] command_word;
  logic [CMD_WIDTH-1:0] next_command;
  logic command_go;
  command_type cmd;

  // synchronisers for the pins
  logic clear_meta;
  logic clear_pin_n;
  logic coding_meta;
  logic coding_twos;

  // control state
  logic clear_code_select;
  logic clear_command;
  logic clear_active;
  logic [RANGE_WIDTH-1:0] range [NUM_CHANNELS];
  logic [CODE_WIDTH-1:0] dac_code [NUM_CHANNELS];
  logic [CODE_WIDTH-1:0] readback;
  logic [CODE_WIDTH-1:0] next_readback;
  logic [31:0] read_word;
  logic read_ok;
  logic read_channel;

  // protection bits are accepted and ignored
  logic unused_prot;
  assign unused_prot = ^{awprot, arprot};

  // fields of the held command word, in the serial word's bit order
  assign cmd = command_type'(command_word);

  // two flip-flops before any logic sees the pins
  // a pin pulse shorter than one clock period can be missed entirely
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clear_meta <= 1'b1;
      clear_pin_n <= 1'b1;
      coding_meta <= 1'b0;
      coding_twos <= 1'b0;
    end else begin
      clear_meta <= output_clear_n;
      clear_pin_n <= clear_meta;
      coding_meta <= bipolar_coding_select_pin;
      coding_twos <= coding_meta;
    end
  end

  // address and data are each taken once and held until the write runs
  assign awready = !aw_held;
  assign wready = !w_held;
  assign write_fire = aw_held && w_held && !bvalid;
  assign write_hits_command = (aw_addr == OFFSET_COMMAND);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (awvalid && !aw_held) begin
      aw_held <= 1'b1;
      aw_addr <= awaddr;
    end else if (write_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (wvalid && !w_held) begin
      w_held <= 1'b1;
      w_data <= wdata;
      w_strb <= wstrb;
    end else if (write_fire) begin
      w_held <= 1'b0;
    end
  end

  // only the command word is writable; everything else answers with an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (write_fire) begin
      bvalid <= 1'b1;
      bresp <= write_hits_command ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // byte lanes merge into the held command; the top lane is outside the word
  always_comb begin
    next_command = command_word;
    for (int b = 0; b < CMD_WIDTH / 8; b++) begin
      if (w_strb[b]) begin
        next_command[b*8 +: 8] = w_data[b*8 +: 8];
      end
    end
  end

  // R18 command word capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      command_word <= '0;
      command_go <= 1'b0;
    end else begin
      command_go <= write_fire && write_hits_command;
      if (write_fire && write_hits_command) begin
        command_word <= next_command;
      end
    end
  end

  // R04 clear command decode
  assign clear_command = command_go && !cmd.rw && (cmd.reg_select == REG_CONTROL)
    && (cmd.channel_address == CTRL_CLEAR);
  // the command pulse lasts one cycle; the pin clears every cycle it is low
  // R01 pin or command clears
  assign clear_active = !clear_pin_n || clear_command;

  // R05 clear select resets to zero-scale
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clear_code_select <= 1'b0;
    end else if (command_go && !cmd.rw && (cmd.reg_select == REG_CONTROL)
        && (cmd.channel_address == CTRL_CONFIG)) begin
      clear_code_select <= cmd.data[CLEAR_SELECT_BIT];
    end
  end

  // R05 reference starts powered down
  // R10 stays down unless software raises it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reference_powered <= 1'b0;
    end else if (command_go && !cmd.rw && (cmd.reg_select == REG_POWER)) begin
      reference_powered <= cmd.data[POWER_REF_BIT];
    end
  end

  // one slice per channel: range, power, data register and mapper
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_channel
      logic hit;
      logic bipolar;
      logic [CODE_WIDTH-1:0] clear_code;

      assign hit = (cmd.channel_address == ADDR_CH_ALL)
        || (cmd.channel_address == ((ch == 0) ? ADDR_CH_A : ADDR_CH_B));
      // same bipolar test as the mapper; both must follow the range table
      assign bipolar = (range[ch] == RANGE_BI_5) || (range[ch] == RANGE_BI_10)
        || (range[ch] == RANGE_BI_10P8);
      // twos complement puts zero-scale and midscale at msb-flipped codes
      assign clear_code = (clear_code_select ? CODE_MIDSCALE : CODE_ZERO_SCALE)
        ^ ((bipolar && coding_twos) ? CODE_MSB_FLIP : CODE_ZERO_SCALE);

      // R06 reset range is 5 V unipolar
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          range[ch] <= RANGE_UNI_5;
        end else if (command_go && !cmd.rw && (cmd.reg_select == REG_RANGE) && hit) begin
          range[ch] <= cmd.data[RANGE_WIDTH-1:0];
        end
      end

      // R05 channels start powered down
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          channel_powered[ch] <= 1'b0;
        end else if (command_go && !cmd.rw && (cmd.reg_select == REG_POWER)) begin
          channel_powered[ch] <= cmd.data[ch * POWER_CH_STRIDE];
        end
      end

      // R01 R19 clear loads data register
      // R03 clear wins over any write
      // R02 cleared code held afterwards
      // R09 powered-down writes dropped
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          dac_code[ch] <= CODE_ZERO_SCALE;
        end else if (clear_active) begin
          dac_code[ch] <= clear_code;
        end else if (command_go && !cmd.rw && (cmd.reg_select == REG_DAC) && hit
            && channel_powered[ch]) begin
          dac_code[ch] <= cmd.data;
        end
      end

      channel_code_mapper u_mapper (
        .aclk(aclk),
        .aresetn(aresetn),
        .code(dac_code[ch]),
        .range(range[ch]),
        .twos_complement(coding_twos),
        .mapped(channel_out[ch])
      );
    end
  endgenerate

  // a read command selects which internal register lands in readback
  assign read_channel = (cmd.channel_address == ADDR_CH_B);

  always_comb begin
    next_readback = readback;
    unique case (cmd.reg_select)
      REG_DAC: next_readback = dac_code[read_channel];
      REG_RANGE: next_readback = {{(CODE_WIDTH-RANGE_WIDTH){1'b0}}, range[read_channel]};
      REG_POWER: begin
        next_readback = '0;
        next_readback[POWER_REF_BIT] = reference_powered;
        for (int c = 0; c < NUM_CHANNELS; c++) begin
          next_readback[c * POWER_CH_STRIDE] = channel_powered[c];
        end
      end
      REG_CONTROL: begin
        next_readback = '0;
        next_readback[CLEAR_SELECT_BIT] = clear_code_select;
      end
      default: next_readback = '0; // unassigned selects read as zero
    endcase
  end

  // readback moves only on a read command, so later writes leave it alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      readback <= '0;
    end else if (command_go && cmd.rw) begin
      readback <= next_readback;
    end
  end

  // read address decode
  always_comb begin
    read_word = '0;
    read_ok = 1'b1;
    unique case (araddr)
      OFFSET_COMMAND: read_word[CMD_WIDTH-1:0] = command_word;
      OFFSET_READBACK: read_word[CODE_WIDTH-1:0] = readback;
      OFFSET_STATUS: begin
        read_word[STATUS_CLEAR_PIN_BIT] = !clear_pin_n;
        read_word[STATUS_CLEAR_SELECT_BIT] = clear_code_select;
        read_word[STATUS_REF_BIT] = reference_powered;
        read_word[STATUS_POWER_LSB +: NUM_CHANNELS] = channel_powered;
        for (int c = 0; c < NUM_CHANNELS; c++) begin
          read_word[STATUS_RANGE_LSB + c * STATUS_RANGE_STRIDE +: RANGE_WIDTH] = range[c];
        end
      end
      OFFSET_LEVEL_A: begin
        read_word[LEVEL_WIDTH-1:0] = channel_out[0].level;
        read_word[LEVEL_GAIN_LSB +: GAIN_WIDTH] = channel_out[0].gain_x100;
      end
      OFFSET_LEVEL_B: begin
        read_word[LEVEL_WIDTH-1:0] = channel_out[1].level;
        read_word[LEVEL_GAIN_LSB +: GAIN_WIDTH] = channel_out[1].gain_x100;
      end
      default: read_ok = 1'b0;
    endcase
  end

  // one read in flight; a new address waits until the answer is taken
  assign arready = !rvalid;

  // data is captured with the address and stands until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arvalid && !rvalid) begin
      rvalid <= 1'b1;
      rdata <= read_word;
      rresp <= read_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule : dac_clear_and_code_mapping

// ==== dac_checker_properties.sv ====
`timescale 1ns/1ns
module dac_checker
  import dac_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic output_clear_n,
  input wire logic bipolar_coding_select_pin,
  input channel_out_type channel_out [NUM_CHANNELS],
  input wire logic [NUM_CHANNELS-1:0] channel_powered,
  input wire logic reference_powered
);
  // shorthand views of the two channels
  wire [15:0] code_a = channel_out[0].code;
  wire [15:0] code_b = channel_out[1].code;
  wire [16:0] level_a = channel_out[0].level;
  wire [9:0] gain_a = channel_out[0].gain_x100;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  reset_state_a: assert property (
    $rose(aresetn) |-> channel_powered == 2'b00 && !reference_powered
      && code_a == 16'h0000 && gain_a == 10'h0C8) else $error("reset state wrong");
  // eight low cycles leave room for the pin synchroniser and mapper
  clear_code_a: assert property (
    !output_clear_n [*8] |-> code_a inside {16'h0000, 16'h8000}
      && code_b inside {16'h0000, 16'h8000}) else $error("clear code missing");
  clear_hold_a: assert property (
    !output_clear_n [*8] |-> $stable(code_a) && $stable(code_b)) else $error("update in clear");
  // with no write offered and the clear pin high, channel A's code cannot move
  idle_hold_a: assert property (
    (output_clear_n && !awvalid) [*6] |-> $stable(code_a)) else $error("code moved idle");
  uni_map_a: assert property (
    gain_a inside {10'h0C8, 10'h1B0} |-> level_a == {1'b0, code_a}) else $error("uni map");
  twos_map_a: assert property (
    (gain_a inside {10'h320, 10'h360} && bipolar_coding_select_pin) [*8]
      |-> level_a == {code_a[15], code_a}) else $error("twos map");
  offset_map_a: assert property (
    (gain_a inside {10'h320, 10'h360} && !bipolar_coding_select_pin) [*8]
      |-> level_a == {1'b0, code_a} - 17'h08000) else $error("offset map");
  drop_write_a: assert property (
    !channel_powered[0] [*8] |-> $stable(code_a) || code_a inside {16'h0000, 16'h8000})
    else $error("write to powered-down channel");
  // both taken at one edge, write runs at the next, response seen one edge later
  write_resp_a: assert property (
    awvalid && awready && wvalid && wready && !bvalid |-> ##2 bvalid) else $error("no bvalid");
  read_resp_a: assert property (
    arvalid && arready |=> rvalid && !arready) else $error("no rvalid");
endmodule : dac_checker

bind dac_clear_and_code_mapping dac_checker checker_inst (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .arvalid, .arready,
  .rvalid, .output_clear_n, .bipolar_coding_select_pin, .channel_out, .channel_powered,
  .reference_powered
);

// ==== host_bus_model.sv ====
`timescale 1ns/1ns
module host_bus_model
  import dac_pkg::*;
(
  input wire logic aclk,
  input wire logic awready,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic [AXI_ADDR_WIDTH-1:0] awaddr,
  output logic awvalid,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  output logic bready,
  output logic [AXI_ADDR_WIDTH-1:0] araddr,
  output logic arvalid,
  output logic rready
);
  // idle bus at time zero
  initial begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
  end

  // released payloads show the inverse so stale values never look valid
  task automatic write_word(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end while (!bvalid);
    bready <= 1'b0;
    r = bresp;
  endtask : write_word

  task automatic read_word(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask : read_word
endmodule : host_bus_model

// ==== tb_dac_clear_and_code_mapping.sv ====
`timescale 1ns/1ns
module tb_dac_clear_and_code_mapping
  import dac_pkg::*;
;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, output_clear_n, bipolar_coding_select_pin;
  logic [AXI_ADDR_WIDTH-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  channel_out_type channel_out [NUM_CHANNELS];
  logic [NUM_CHANNELS-1:0] channel_powered;
  logic reference_powered;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  // gain in hundredths per range code
  logic [9:0] gains [6] = '{10'h0C8, 10'h190, 10'h1B0, 10'h190, 10'h320, 10'h360};

  dac_clear_and_code_mapping DUT (
    .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .output_clear_n, .bipolar_coding_select_pin, .channel_out,
    .channel_powered, .reference_powered
  );
  host_bus_model host (
    .aclk, .awready, .wready, .bresp, .bvalid, .arready, .rdata, .rresp, .rvalid, .awaddr,
    .awvalid, .wdata, .wstrb, .wvalid, .bready, .araddr, .arvalid, .rready
  );

  task automatic wrap_up;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // one command word, then three edges for execute and mapper
  task automatic send(input logic [2:0] sel, input logic [2:0] ch, input logic [15:0] d);
    logic [1:0] r;
    host.write_word(OFFSET_COMMAND, {8'h00, 2'b00, sel, ch, d}, r);
    cmp({30'h0, r}, {30'h0, RESP_OKAY});
    repeat (3) @(posedge aclk);
  endtask : send

  // step count expected from range, coding pin and code
  function automatic logic [16:0] lvl(input logic [2:0] rng, input logic tc, input logic [15:0] c);
    if (rng < 3'h3) return {1'b0, c};
    if (tc) return {c[15], c};
    return {1'b0, c} - 17'h08000;
  endfunction : lvl

  task automatic chk_ch(input logic [2:0] rng, input logic tc, input logic [15:0] c);
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      cmp({16'h0, channel_out[i].code}, {16'h0, c});
      cmp({15'h0, channel_out[i].level}, {15'h0, lvl(rng, tc, c)});
      cmp({22'h0, channel_out[i].gain_x100}, {22'h0, gains[rng]});
    end
  endtask : chk_ch

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    cmp({29'h0, channel_powered, reference_powered}, 32'h0);
    chk_ch(3'h0, 1'b0, 16'h0000);
    host.read_word(OFFSET_STATUS, d, r);
    cmp(d, 32'h0);
    @(posedge aclk); // let rready fall before the next read
    host.read_word(8'h40, d, r);
    cmp({30'h0, r}, {30'h0, RESP_SLVERR});
    $display("reset test done");
  endtask : t_reset

  task automatic t_power;
    send(REG_RANGE, ADDR_CH_ALL, 16'h0000);
    send(REG_DAC, ADDR_CH_ALL, 16'h1234);
    chk_ch(3'h0, 1'b0, 16'h0000);
    send(REG_POWER, ADDR_CH_A, 16'h0005);
    cmp({29'h0, channel_powered, reference_powered}, 32'h6);
    send(REG_POWER, ADDR_CH_A, 16'h0015);
    cmp({29'h0, channel_powered, reference_powered}, 32'h7);
    send(REG_DAC, ADDR_CH_ALL, 16'h1234);
    chk_ch(3'h0, 1'b0, 16'h1234);
    $display("power test done");
  endtask : t_power

  // every range under both coding pin levels, at the code boundaries
  task automatic t_codes;
    logic [15:0] codes [4] = '{16'h0000, 16'h7FFF, 16'h8000, 16'hFFFF};
    for (int p = 0; p < 2; p++) begin
      bipolar_coding_select_pin <= p[0];
      for (int r = 0; r < 6; r++) begin
        send(REG_RANGE, ADDR_CH_ALL, {13'h0, r[2:0]});
        for (int k = 0; k < 4; k++) begin
          send(REG_DAC, ADDR_CH_ALL, codes[k]);
          chk_ch(r[2:0], p[0], codes[k]);
        end
      end
    end
    $display("coding test done");
  endtask : t_codes

  task automatic t_clr_pin;
    logic [31:0] d;
    logic [1:0] r;
    bipolar_coding_select_pin <= 1'b0;
    send(REG_RANGE, ADDR_CH_ALL, 16'h0003);
    send(REG_CONTROL, CTRL_CONFIG, 16'h0004);
    send(REG_DAC, ADDR_CH_ALL, 16'h1234);
    output_clear_n <= 1'b0;
    repeat (8) @(posedge aclk);
    chk_ch(3'h3, 1'b0, 16'h8000);
    host.read_word(OFFSET_STATUS, d, r);
    cmp(d, 32'h0000_3337);
    send(REG_DAC, ADDR_CH_ALL, 16'h4321);
    chk_ch(3'h3, 1'b0, 16'h8000);
    output_clear_n <= 1'b1;
    repeat (8) @(posedge aclk);
    chk_ch(3'h3, 1'b0, 16'h8000);
    host.write_word(OFFSET_COMMAND, 32'h0080_0000, r);
    host.read_word(OFFSET_READBACK, d, r);
    cmp(d, 32'h0000_8000);
    send(REG_DAC, ADDR_CH_ALL, 16'h4321);
    chk_ch(3'h3, 1'b0, 16'h4321);
    host.read_word(OFFSET_LEVEL_B, d, r);
    cmp(d, 32'h1901_C321);
    $display("clear pin test done");
  endtask : t_clr_pin

  task automatic t_clr_cmd;
    logic [1:0] r;
    send(REG_RANGE, ADDR_CH_ALL, 16'h0000);
    send(REG_CONTROL, CTRL_CONFIG, 16'h0000);
    send(REG_DAC, ADDR_CH_ALL, 16'h5555);
    send(REG_CONTROL, CTRL_CLEAR, 16'h0000);
    chk_ch(3'h0, 1'b0, 16'h0000);
    host.write_word(OFFSET_READBACK, 32'h0, r);
    cmp({30'h0, r}, {30'h0, RESP_SLVERR});
    $display("clear command test done");
  endtask : t_clr_cmd

  // clock at 250 MHz
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // watchdog far above the few hundred cycles the scenarios need
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      wrap_up;
    end
  end

  // five cycles of reset, then the scenarios in order
  initial begin
    aresetn = 1'b0;
    output_clear_n = 1'b1;
    bipolar_coding_select_pin = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_power;
    t_codes;
    t_clr_pin;
    t_clr_cmd;
    wrap_up;
  end
endmodule : tb_dac_clear_and_code_mapping
